// File: include/dcs_regs.vh
// Register map, field positions, reset values and sizes of the channel status block
`ifndef DCS_REGS_VH
`define DCS_REGS_VH

`define DCS_NUM_CH 12
`define DCS_NUM_LVL 4
`define DCS_ADDR_W 8

`define DCS_OFF_BUSY 8'h28
`define DCS_OFF_PEND 8'h2C
`define DCS_OFF_ACTIVE 8'h30
`define DCS_OFF_DESC_BASE 8'h34
`define DCS_OFF_WB_BASE 8'h38
`define DCS_OFF_INT_STAT 8'h50
`define DCS_OFF_INT_MASK 8'h54

`define DCS_RST_BUSY 32'h00000000
`define DCS_RST_PEND 32'h00000000
`define DCS_RST_ACTIVE 32'h00000000
`define DCS_RST_DESC_BASE 32'h00000000
`define DCS_RST_WB_BASE 32'h00000000
`define DCS_RST_INT 3'h0

`define DCS_ACT_CNT_LSB 16
`define DCS_ACT_CNT_MSB 31
`define DCS_ACT_BUSY_BIT 15
`define DCS_ACT_ID_LSB 8
`define DCS_ACT_ID_MSB 12
`define DCS_ACT_LVL_LSB 0
`define DCS_ACT_LVL_MSB 3

`define DCS_INT_W 3
`define DCS_INT_BUS_ERR 0
`define DCS_INT_ACT_DONE 1
`define DCS_INT_ABORT 2

// One descriptor or write-back slot is 128 bits
`define DCS_SLOT_SHIFT 4
`define DCS_ALIGN_MASK 32'h0000000F

`endif

// File: hdl/dcs_chan_track.v
// Busy, pending and enable tracking for one DMA channel
`timescale 1ns/1ps
module dcs_chan_track
(
   input wire ref_clk_i,
   input wire reset_n_i,
   input wire en_req_i,
   input wire buf_empty_i,
   input wire pend_set_i,
   input wire trig_start_i,
   input wire xfer_start_i,
   input wire act_done_i,
   input wire bus_err_i,
   output wire busy_o,
   output wire pend_o,
   output wire enabled_o,
   output wire abort_o
);
   reg busy_ff;
   reg pend_ff;
   reg en_ff;
   reg abort_ff;
   wire nxt_en;
   wire nxt_busy;
   wire nxt_pend;
   wire dis_now;

   // A disable request during a burst waits for the data buffer to drain
   assign nxt_en = en_req_i | (en_ff & busy_ff & ~buf_empty_i);
   assign dis_now = en_ff & ~nxt_en;
   // Start wins over action done or bus error in the same cycle, but not over a disable
   assign nxt_busy = en_ff & nxt_en & xfer_start_i |
                     (busy_ff & nxt_en & ~act_done_i & ~bus_err_i);
   assign nxt_pend = en_ff & nxt_en & pend_set_i |
                     (pend_ff & nxt_en & ~trig_start_i & ~bus_err_i);

   always @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         busy_ff <= 1'b0;
         pend_ff <= 1'b0;
         en_ff <= 1'b0;
         abort_ff <= 1'b0;
      end
      else
      begin
         busy_ff <= nxt_busy;
         pend_ff <= nxt_pend;
         en_ff <= nxt_en;
         abort_ff <= dis_now & busy_ff;
      end
   end

   assign busy_o = busy_ff;
   assign pend_o = pend_ff;
   assign enabled_o = en_ff;
   assign abort_o = abort_ff;
endmodule

// File: hdl/dcs_top.v
// Channel status, active channel and section base registers of the DMA controller
//
// Contract
// - A channel's busy flag sets when that channel starts a transfer.
// - Busy clears on trigger action done, bus error or channel disable.
// - A channel's pending flag sets while a transfer waits on it.
// - Pending clears on trigger execution start, bus error or channel disable.
// - Active block count is readable and written back on each new grant; here only on grants that find the active slot occupied.
// - Active block count is valid only while the active slot is occupied.
// - Occupied flag sets on write-back count fetch, clears after write-back.
// - Five-bit active channel index updates on every arbiter grant.
// - One bit per priority level, set while a request of it runs or waits.
// - Read-write descriptor base; descriptors are fetched relative to it.
// - Reserved bits read zero; software writes zero to them.
// - Read-write write-back base, programmed 128-bit aligned, locates write-back.
// - Channel disable waits for buffer drain after burst, then aborts.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "dcs_regs.vh"
module dcs_top
#(
   parameter NUM_CH = `DCS_NUM_CH,
   parameter NUM_LVL = `DCS_NUM_LVL
)
(
   input wire ref_clk_i,
   input wire reset_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   input wire [NUM_CH-1:0] chan_en_req_i,
   input wire [2*NUM_CH-1:0] chan_level_i,
   input wire buf_empty_i,
   input wire [NUM_CH-1:0] trig_pend_i,
   input wire [NUM_CH-1:0] trig_start_i,
   input wire [NUM_CH-1:0] xfer_start_i,
   input wire [NUM_CH-1:0] act_done_i,
   input wire [NUM_CH-1:0] bus_err_i,
   input wire grant_i,
   input wire [4:0] grant_id_i,
   input wire wb_fetch_done_i,
   input wire [15:0] wb_fetch_count_i,
   input wire beat_done_i,
   input wire wb_write_ack_i,
   output wire [NUM_CH-1:0] chan_enabled_o,
   output wire [NUM_CH-1:0] chan_abort_o,
   output wire desc_fetch_o,
   output wire [31:0] desc_addr_o,
   output wire wb_write_o,
   output wire [31:0] wb_addr_o,
   output wire [15:0] wb_data_o,
   output wire irq_o
);
   wire [NUM_CH-1:0] busy_w, pend_w, en_w, abort_w;
   reg [NUM_CH-1:0] en_out_ff, abort_out_ff;
   reg [31:0] desc_base_ff, wb_base_ff;
   reg [15:0] act_count_ff;
   reg act_busy_ff;
   reg [4:0] act_id_ff;
   reg [NUM_LVL-1:0] lvl_exec_ff, nxt_lvl_exec;
   reg desc_fetch_ff, wb_write_ff;
   reg [31:0] desc_addr_ff, wb_addr_ff;
   reg [15:0] wb_data_ff;
   reg [`DCS_INT_W-1:0] int_stat_ff, int_mask_ff, nxt_int_stat;
   wire [`DCS_INT_W-1:0] int_event;
   reg irq_ff;
   reg [31:0] prdata_ff, nxt_rdata;
   reg pready_ff, pslverr_ff, nxt_hit;
   wire apb_setup, apb_done, wr_done;
   integer lvl_i, ch_i;
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g = g + 1)
      begin : g_chan
         dcs_chan_track u_track
         (
            .ref_clk_i(ref_clk_i),
            .reset_n_i(reset_n_i),
            .en_req_i(chan_en_req_i[g]),
            .buf_empty_i(buf_empty_i),
            .pend_set_i(trig_pend_i[g]),
            .trig_start_i(trig_start_i[g]),
            .xfer_start_i(xfer_start_i[g]),
            .act_done_i(act_done_i[g]),
            .bus_err_i(bus_err_i[g]),
            .busy_o(busy_w[g]),
            .pend_o(pend_w[g]),
            .enabled_o(en_w[g]),
            .abort_o(abort_w[g])
         );
      end
   endgenerate

   // Retimed so that every top output leaves from a flop
   always @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         en_out_ff <= {NUM_CH{1'b0}};
         abort_out_ff <= {NUM_CH{1'b0}};
      end
      else
      begin
         en_out_ff <= en_w;
         abort_out_ff <= abort_w;
      end
   end

   // APB: setup, then one access cycle with pready high
   assign apb_setup = psel_i & ~penable_i;
   assign apb_done = psel_i & penable_i & pready_ff;
   assign wr_done = apb_done & pwrite_i & ~pslverr_ff;

   always @*
   begin
      nxt_rdata = 32'h00000000;
      nxt_hit = 1'b1;
      case (paddr_i)
         `DCS_OFF_BUSY:
         begin
            nxt_rdata[NUM_CH-1:0] = busy_w;
         end
         `DCS_OFF_PEND:
         begin
            nxt_rdata[NUM_CH-1:0] = pend_w;
         end
         `DCS_OFF_ACTIVE:
         begin
            nxt_rdata[`DCS_ACT_CNT_MSB:`DCS_ACT_CNT_LSB] = act_count_ff;
            nxt_rdata[`DCS_ACT_BUSY_BIT] = act_busy_ff;
            nxt_rdata[`DCS_ACT_ID_MSB:`DCS_ACT_ID_LSB] = act_id_ff;
            nxt_rdata[`DCS_ACT_LVL_MSB:`DCS_ACT_LVL_LSB] = lvl_exec_ff;
         end
         `DCS_OFF_DESC_BASE:
         begin
            nxt_rdata = desc_base_ff;
         end
         `DCS_OFF_WB_BASE:
         begin
            nxt_rdata = wb_base_ff;
         end
         `DCS_OFF_INT_STAT:
         begin
            nxt_rdata[`DCS_INT_W-1:0] = int_stat_ff;
         end
         `DCS_OFF_INT_MASK:
         begin
            nxt_rdata[`DCS_INT_W-1:0] = int_mask_ff;
         end
         default:
         begin
            nxt_hit = 1'b0;
         end
      endcase
      // Word-aligned access only
      if (paddr_i[1:0] != 2'h0)
      begin
         nxt_hit = 1'b0;
      end
   end

   always @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else if (apb_setup)
      begin
         prdata_ff <= pwrite_i ? 32'h00000000 : nxt_rdata;
         pready_ff <= 1'b1;
         pslverr_ff <= ~nxt_hit;
      end
      else if (apb_done)
      begin
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   // Base registers; alignment is left to software, low bits are stored as written
   always @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         desc_base_ff <= `DCS_RST_DESC_BASE;
         wb_base_ff <= `DCS_RST_WB_BASE;
         int_mask_ff <= `DCS_RST_INT;
      end
      else if (wr_done)
      begin
         if (paddr_i == `DCS_OFF_DESC_BASE)
         begin
            desc_base_ff <= pwdata_i;
         end
         if (paddr_i == `DCS_OFF_WB_BASE)
         begin
            wb_base_ff <= pwdata_i;
         end
         if (paddr_i == `DCS_OFF_INT_MASK)
         begin
            int_mask_ff <= pwdata_i[`DCS_INT_W-1:0];
         end
      end
   end

   // Active channel slot
   always @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         act_count_ff <= 16'h0000;
         act_busy_ff <= 1'b0;
         act_id_ff <= 5'h00;
         desc_fetch_ff <= 1'b0;
         desc_addr_ff <= 32'h00000000;
         wb_write_ff <= 1'b0;
         wb_addr_ff <= 32'h00000000;
         wb_data_ff <= 16'h0000;
      end
      else
      begin
         desc_fetch_ff <= 1'b0;
         wb_write_ff <= 1'b0;
         if (grant_i)
         begin
            act_id_ff <= grant_id_i;
            desc_fetch_ff <= 1'b1;
            desc_addr_ff <= desc_base_ff + {23'h000000, grant_id_i, 4'h0};
            if (act_busy_ff)
            begin
               // Outgoing channel's count goes back to its own slot
               wb_write_ff <= 1'b1;
               wb_data_ff <= act_count_ff;
               wb_addr_ff <= wb_base_ff + {23'h000000, act_id_ff, 4'h0};
            end
         end
         if (wb_fetch_done_i)
         begin
            act_count_ff <= wb_fetch_count_i;
            act_busy_ff <= 1'b1;
         end
         else
         begin
            if (beat_done_i && act_busy_ff && act_count_ff != 16'h0000)
            begin
               act_count_ff <= act_count_ff - 16'h0001;
            end
            if (wb_write_ack_i)
            begin
               act_busy_ff <= 1'b0;
            end
         end
      end
   end

   // Level bits from every busy or waiting channel of that level
   always @*
   begin
      nxt_lvl_exec = {NUM_LVL{1'b0}};
      for (lvl_i = 0; lvl_i < NUM_LVL; lvl_i = lvl_i + 1)
      begin
         for (ch_i = 0; ch_i < NUM_CH; ch_i = ch_i + 1)
         begin
            if ((busy_w[ch_i] | pend_w[ch_i]) &&
                chan_level_i[2*ch_i +: 2] == lvl_i[1:0])
            begin
               nxt_lvl_exec[lvl_i] = 1'b1;
            end
         end
      end
   end

   always @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         lvl_exec_ff <= {NUM_LVL{1'b0}};
      end
      else
      begin
         lvl_exec_ff <= nxt_lvl_exec;
      end
   end

   // Sticky events; a new event wins over a same-cycle clear
   assign int_event[`DCS_INT_BUS_ERR] = |bus_err_i;
   assign int_event[`DCS_INT_ACT_DONE] = |act_done_i;
   assign int_event[`DCS_INT_ABORT] = |abort_w;

   always @*
   begin
      nxt_int_stat = int_stat_ff;
      if (wr_done && paddr_i == `DCS_OFF_INT_STAT)
      begin
         nxt_int_stat = int_stat_ff & ~pwdata_i[`DCS_INT_W-1:0];
      end
      nxt_int_stat = nxt_int_stat | int_event;
   end

   always @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         int_stat_ff <= `DCS_RST_INT;
         irq_ff <= 1'b0;
      end
      else
      begin
         int_stat_ff <= nxt_int_stat;
         irq_ff <= |(nxt_int_stat & int_mask_ff);
      end
   end

   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign chan_enabled_o = en_out_ff;
   assign chan_abort_o = abort_out_ff;
   assign desc_fetch_o = desc_fetch_ff;
   assign desc_addr_o = desc_addr_ff;
   assign wb_write_o = wb_write_ff;
   assign wb_addr_o = wb_addr_ff;
   assign wb_data_o = wb_data_ff;
   assign irq_o = irq_ff;
endmodule

// File: tb/dcs_top_props.sv
// Port-level assertions for the channel status block
`timescale 1ns/1ps
module dcs_top_props
#(
   parameter NUM_CH = 12
)
(
   input wire ref_clk_i,
   input wire reset_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire [7:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   input wire grant_i,
   input wire desc_fetch_o,
   input wire wb_write_o,
   input wire [NUM_CH-1:0] chan_abort_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   a_ready_setup:
   assert property (psel_i && !penable_i |=> pready_o) else $error("no ready");
   a_ready_once:
   assert property (pready_o |-> psel_i && penable_i ##1 !pready_o) else $error("long ready");
   a_err_misalign:
   assert property (psel_i && !penable_i && paddr_i[1:0] != 2'h0 |=> pslverr_o)
      else $error("no error");
   a_err_ready:
   assert property (pslverr_o |-> pready_o) else $error("stray error");
   a_rdata_idle:
   assert property (!pready_o |-> prdata_o == 32'h0) else $error("stray rdata");
   a_fetch_grant:
   assert property (grant_i |=> desc_fetch_o) else $error("no fetch");
   a_fetch_cause:
   assert property (desc_fetch_o |-> $past(grant_i)) else $error("stray fetch");
   a_wb_cause:
   assert property (wb_write_o |-> desc_fetch_o && $past(grant_i)) else $error("stray wb");
   a_abort_pulse:
   assert property ((chan_abort_o & $past(chan_abort_o)) == {NUM_CH{1'b0}})
      else $error("long abort");
endmodule
bind dcs_top dcs_top_props #(.NUM_CH(NUM_CH)) u_props (.ref_clk_i(ref_clk_i),
   .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .grant_i(grant_i),
   .desc_fetch_o(desc_fetch_o), .wb_write_o(wb_write_o), .chan_abort_o(chan_abort_o));

// File: tb/dcs_mem_model.sv
// Far-side memory answering write-back and descriptor count fetches
`timescale 1ns/1ps
module dcs_mem_model
#(
   parameter DLY = 3
)
(
   input wire ref_clk_i,
   input wire reset_n_i,
   input wire fetch_req_i,
   input wire write_req_i,
   input wire [15:0] next_count_i,
   output reg fetch_done_o,
   output reg [15:0] fetch_count_o,
   output reg write_ack_o
);
   reg [3:0] fetch_ff;
   reg [3:0] write_ff;
   // Write-back lands before the fetch, else the slot would clear late
   always @(posedge ref_clk_i)
   begin
      if (!reset_n_i)
      begin
         fetch_ff <= 4'h0;
         write_ff <= 4'h0;
         fetch_done_o <= 1'b0;
         write_ack_o <= 1'b0;
         fetch_count_o <= 16'h0000;
      end
      else
      begin
         fetch_ff <= fetch_req_i ? 4'(DLY + 2) : fetch_ff - {3'h0, fetch_ff != 4'h0};
         write_ff <= write_req_i ? 4'(DLY) : write_ff - {3'h0, write_ff != 4'h0};
         fetch_done_o <= fetch_ff == 4'h1;
         write_ack_o <= write_ff == 4'h1;
         // Count bus shows garbage outside the answer
         fetch_count_o <= fetch_ff == 4'h1 ? next_count_i : ~next_count_i;
      end
   end
endmodule

// File: tb/dcs_top_tb.sv
// Register and channel scenarios for the channel status block
`timescale 1ns/1ps
module dcs_top_tb;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [11:0] en = 12'h000, pend = 12'h000, tst = 12'h000;
   logic [11:0] xst = 12'h000, done = 12'h000, berr = 12'h000;
   logic buf_empty_i = 1'b0, grant_i = 1'b0, beat = 1'b0;
   logic [4:0] gid = 5'h00;
   logic [23:0] lvl = 24'h000080;
   logic [15:0] ncnt = 16'h0007;
   wire [31:0] prdata_o, desc_addr_o, wb_addr_o;
   wire pready_o, pslverr_o, desc_fetch_o, wb_write_o, irq_o, fdone, wack;
   wire [15:0] fcnt, wb_data_o;
   wire [11:0] ena, abt;
   logic [31:0] r;
   logic e;
   integer num_errors = 0, samples_checked = 0;
   dcs_top DUT (.ref_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .chan_en_req_i(en),
      .chan_level_i(lvl), .buf_empty_i, .trig_pend_i(pend), .trig_start_i(tst),
      .xfer_start_i(xst), .act_done_i(done), .bus_err_i(berr), .grant_i,
      .grant_id_i(gid), .wb_fetch_done_i(fdone), .wb_fetch_count_i(fcnt),
      .beat_done_i(beat), .wb_write_ack_i(wack), .chan_enabled_o(ena),
      .chan_abort_o(abt), .desc_fetch_o, .desc_addr_o, .wb_write_o, .wb_addr_o,
      .wb_data_o, .irq_o);
   dcs_mem_model u_mem (.ref_clk_i, .reset_n_i, .fetch_req_i(desc_fetch_o),
      .write_req_i(wb_write_o), .next_count_i(ncnt), .fetch_done_o(fdone),
      .fetch_count_o(fcnt), .write_ack_o(wack));
   initial
      forever #2.5 ref_clk_i = ~ref_clk_i;
   task summarize;
      begin
         $display("errors %0d checks %0d", num_errors, samples_checked);
         if (num_errors == 0 && samples_checked > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      begin
         samples_checked++;
         if (s !== x)
         begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, x, s);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      begin
         psel_i <= 1'b1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= d;
         cyc(1);
         penable_i <= 1'b1;
         n = 0;
         do
         begin
            cyc(1);
            n++;
         end
         while (pready_o !== 1'b1 && n < 20);
         if (n >= 20)
         begin
            num_errors++;
            summarize;
         end
         r = prdata_o;
         e = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
         cyc(1);
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      begin
         apb(1'b0, a, 32'h0);
         chk($sformatf("reg %h", a), r, x);
      end
   endtask
   task grant(input logic [4:0] id);
      begin
         grant_i <= 1'b1;
         gid <= id;
         cyc(1);
         grant_i <= 1'b0;
         cyc(1);
      end
   endtask
   initial
   begin
      cyc(10);
      reset_n_i <= 1'b1;
      cyc(1);
      for (int i = 0; i < 5; i++)
         rd(8'h28 + 8'(4 * i), 32'h0);
      apb(1'b1, 8'h34, 32'h10000010);
      apb(1'b1, 8'h38, 32'h20000020);
      // Read-only register: the write is ignored and the register still reads zero
      apb(1'b1, 8'h28, 32'h00000FFF);
      rd(8'h34, 32'h10000010);
      rd(8'h38, 32'h20000020);
      rd(8'h28, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", e, 32'h1);
      apb(1'b0, 8'h2A, 32'h0);
      chk("misalign", e, 32'h1);
      apb(1'b1, 8'h54, 32'h7);
      rd(8'h54, 32'h7);
      en <= 12'h028;
      cyc(4);
      chk("enabled", ena, 32'h028);
      pend <= 12'h008;
      cyc(1);
      pend <= 12'h000;
      rd(8'h2C, 32'h8);
      rd(8'h30, 32'h4);
      tst <= 12'h008;
      cyc(1);
      tst <= 12'h000;
      rd(8'h2C, 32'h0);
      xst <= 12'h008;
      cyc(1);
      xst <= 12'h000;
      rd(8'h28, 32'h8);
      done <= 12'h008;
      cyc(1);
      done <= 12'h000;
      rd(8'h28, 32'h0);
      chk("irq", irq_o, 32'h1);
      rd(8'h50, 32'h2);
      apb(1'b1, 8'h50, 32'h2);
      cyc(2);
      chk("irq", irq_o, 32'h0);
      pend <= 12'h020;
      xst <= 12'h020;
      cyc(1);
      pend <= 12'h000;
      xst <= 12'h000;
      rd(8'h28, 32'h20);
      rd(8'h2C, 32'h20);
      berr <= 12'h020;
      cyc(1);
      berr <= 12'h000;
      rd(8'h28, 32'h0);
      rd(8'h2C, 32'h0);
      grant(5'h03);
      chk("fetch", desc_fetch_o, 32'h1);
      chk("faddr", desc_addr_o, 32'h10000040);
      cyc(8);
      rd(8'h30, 32'h00078300);
      beat <= 1'b1;
      cyc(1);
      beat <= 1'b0;
      rd(8'h30, 32'h00068300);
      ncnt <= 16'h0009;
      grant(5'h05);
      chk("faddr", desc_addr_o, 32'h10000060);
      chk("wb", wb_write_o, 32'h1);
      chk("wbaddr", wb_addr_o, 32'h20000050);
      chk("wbdata", wb_data_o, 32'h6);
      cyc(8);
      rd(8'h30, 32'h00098500);
      xst <= 12'h020;
      lvl <= 24'h000C80;
      cyc(1);
      xst <= 12'h000;
      cyc(1);
      // Disable held off while the buffer still holds data
      en <= 12'h008;
      cyc(6);
      chk("enabled", ena, 32'h028);
      rd(8'h28, 32'h20);
      rd(8'h30, 32'h00098508);
      buf_empty_i <= 1'b1;
      cyc(3);
      chk("abort", abt, 32'h020);
      cyc(2);
      chk("enabled", ena, 32'h008);
      rd(8'h28, 32'h0);
      rd(8'h50, 32'h5);
      summarize;
   end
endmodule
